// *** rtl/upp_endpoint.sv ***
// ping-pong IN endpoint: two banks, processor fills one while the other is sent
// assumes the processor keeps the hand-over protocol and the USB side gives
// a one-cycle token strobe and a one-cycle byte-taken strobe
// Function
// [RULE1] two banks: one open to the processor, the other held for sending
// [RULE2] software picks double banking for isochronous or fast bulk traffic; the code has no such choice and is always double-banked
// [RULE3] processor waits for packet-ready clear before the first payload
// [RULE4] processor writes payload bytes for bank 0 through the data register
// [RULE5] setting packet-ready hands the filled bank to the device
// [RULE6] processor may fill bank 1 right away without waiting
// [RULE7] device sets transmit-done once a bank is sent and released
// [RULE8] interrupt stays pending while transmit-done is set
// [RULE9] processor sets packet-ready again after seeing transmit-done
// [RULE10] after hand-over, the other bank is free again; banks alternate
// [RULE11] banks go out strictly in hand-over order, never before hand-over
`include "upp_consts.svh"
`default_nettype none
module upp_endpoint #(
	parameter int DEPTH = `UPP_BANK_DEPTH,
	parameter int CW = `UPP_CNT_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// processor side: data register and control/status flags
	input wire logic fifo_wr,
	input wire logic [`UPP_DATA_W-1:0] fifo_wdata,
	input wire logic set_tx_packet_ready,
	input wire logic clr_tx_done_flag,
	output logic tx_packet_ready,
	output logic tx_done_flag,
	output logic ep_irq,
	output logic cpu_bank,
	// usb side
	input wire logic in_token,
	input wire logic byte_taken,
	output logic tx_valid,
	output logic [`UPP_DATA_W-1:0] tx_data,
	output logic tx_last,
	output logic tx_zlp
);
	upp_pkg::upp_tx_state_e state, next_state;
	logic [1:0] ready_q;     // per bank: handed over and not yet sent
	logic send_bank;         // bank the device sends next
	logic [CW-1:0] idx;
	logic [`UPP_DATA_W-1:0] rd0, rd1;
	logic [CW-1:0] cnt0, cnt1;

	// write steering goes only to the processor's bank
	wire wr0 = fifo_wr && !cpu_bank && !ready_q[0]; // RULE1
	wire wr1 = fifo_wr && cpu_bank && !ready_q[1]; // RULE1
	wire handover = set_tx_packet_ready && !ready_q[cpu_bank];
	wire start = (state == upp_pkg::upp_tx_idle) && in_token && ready_q[send_bank]; // RULE11
	wire [CW-1:0] scnt = send_bank ? cnt1 : cnt0;
	wire [`UPP_DATA_W-1:0] srd = send_bank ? rd1 : rd0;
	wire last_byte = (idx + CW'(1) == scnt);
	wire sent = (state == upp_pkg::upp_tx_send) && ((scnt == '0) || (byte_taken && last_byte));
	wire rel0 = sent && !send_bank;
	wire rel1 = sent && send_bank;
	// index of the byte shown next; the banks are read here so that tx_data
	// loads the byte after a take and never repeats the one just taken
	wire [CW-1:0] next_idx = (sent || start) ? '0 :
		((state == upp_pkg::upp_tx_send && byte_taken) ? idx + CW'(1) : idx);
	wire next_last = (next_idx + CW'(1) == scnt);

	// both banks are read at the lookahead index; only the sending bank's byte is used
	upp_bank #(.DEPTH(DEPTH), .CW(CW)) u_bank0 (
		.core_clk(core_clk), .nrst(nrst), .wr_en(wr0), .wr_data(fifo_wdata),
		.clr(rel0), .rd_idx(next_idx), .rd_data(rd0), .count(cnt0));
	upp_bank #(.DEPTH(DEPTH), .CW(CW)) u_bank1 (
		.core_clk(core_clk), .nrst(nrst), .wr_en(wr1), .wr_data(fifo_wdata),
		.clr(rel1), .rd_idx(next_idx), .rd_data(rd1), .count(cnt1));

	// sender state: wait for a token, stream the bank, release it
	always_comb begin
		next_state = state;
		unique case (state)
			upp_pkg::upp_tx_idle: if (start) next_state = upp_pkg::upp_tx_send;
			upp_pkg::upp_tx_send: if (sent) next_state = upp_pkg::upp_tx_wait;
			upp_pkg::upp_tx_wait: next_state = upp_pkg::upp_tx_idle;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= upp_pkg::upp_tx_idle;
		end else begin
			state <= next_state;
		end
	end

	// hand-over marks the processor bank, release clears the sent one
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ready_q <= 2'h0;
			cpu_bank <= 1'b0;
			send_bank <= 1'b0;
		end else begin
			if (handover) begin
				ready_q[cpu_bank] <= 1'b1; // RULE5
				cpu_bank <= ~cpu_bank; // RULE10
			end
			if (sent) begin
				ready_q[send_bank] <= 1'b0; // RULE7
				send_bank <= ~send_bank; // RULE11
			end
		end
	end

	// byte index within the bank being sent
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			idx <= '0;
		end else begin
			idx <= next_idx;
		end
	end

	// checker helper: bytes the host has taken from the packet on the wire;
	// unlike idx it only counts takes of a shown byte
	logic [CW-1:0] n_taken;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			n_taken <= '0;
		end else if (sent || start) begin
			n_taken <= '0;
		end else if (state == upp_pkg::upp_tx_send && byte_taken && tx_valid) begin
			n_taken <= n_taken + CW'(1);
		end
	end

	// hand-over lands in the bank named by which
	function automatic logic wr_rdy(input logic h, input logic b, input logic which);
		wr_rdy = h && (b == which);
	endfunction

	// flags: a fresh release wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_done_flag <= `UPP_FLAG_RST;
			ep_irq <= `UPP_FLAG_RST;
			tx_packet_ready <= `UPP_FLAG_RST;
		end else begin
			tx_done_flag <= sent | (tx_done_flag & ~clr_tx_done_flag); // RULE7
			ep_irq <= sent | (tx_done_flag & ~clr_tx_done_flag); // RULE8
			tx_packet_ready <= |{ready_q[0] & ~rel0 | wr_rdy(handover, cpu_bank, 1'b0),
				ready_q[1] & ~rel1 | wr_rdy(handover, cpu_bank, 1'b1)};
		end
	end

	// data path registered so every output leaves a flip-flop
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
			tx_zlp <= 1'b0;
		end else begin
			tx_valid <= (next_state == upp_pkg::upp_tx_send) && (scnt != '0) && !sent;
			tx_data <= srd;
			tx_last <= (next_state == upp_pkg::upp_tx_send) && next_last;
			tx_zlp <= start && (scnt == '0);
		end
	end

	// flags and interrupt: set wins over clear, the interrupt mirrors the flag
	chk_done_irq_match: assert property (@(posedge core_clk) disable iff (!nrst) // RULE8
		tx_done_flag == ep_irq) else $error("irq does not follow done flag");
	chk_release_sets_done: assert property (@(posedge core_clk) disable iff (!nrst) // RULE7
		sent |=> tx_done_flag) else $error("release did not set done");
	chk_done_holds: assert property (@(posedge core_clk) disable iff (!nrst) // RULE8
		tx_done_flag && !clr_tx_done_flag && !sent |=> tx_done_flag)
		else $error("done flag lost");
	chk_clear_done: assert property (@(posedge core_clk) disable iff (!nrst) // RULE8
		clr_tx_done_flag && !sent |=> !tx_done_flag && !ep_irq)
		else $error("done flag not cleared");
	chk_zlp_pulse: assert property (@(posedge core_clk) disable iff (!nrst) // RULE7
		tx_zlp |=> !tx_zlp) else $error("zero-length strobe longer than one cycle");

	// ownership: a handed-over bank takes no bytes until the device releases it
	chk_no_write_held: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
		ready_q[0] && !rel0 |=> cnt0 == $past(cnt0))
		else $error("write into held bank 0");
	chk_hold_bank1: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
		ready_q[1] && !rel1 |=> cnt1 == $past(cnt1))
		else $error("write into held bank 1");
	chk_handover_swap: assert property (@(posedge core_clk) disable iff (!nrst) // RULE10
		handover |=> cpu_bank != $past(cpu_bank)) else $error("cpu bank not swapped");
	chk_release_frees: assert property (@(posedge core_clk) disable iff (!nrst) // RULE10
		sent |=> !ready_q[$past(send_bank)]) else $error("released bank still held");
	chk_ready_flag: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
		handover |=> tx_packet_ready) else $error("packet ready not shown");
	chk_ready_level: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
		tx_packet_ready == (ready_q != 2'h0))
		else $error("packet ready disagrees with held banks");

	// sending: strict hand-over order, each stored byte shown until it is taken
	chk_send_needs_ready: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
		tx_valid |-> ready_q[send_bank]) else $error("byte shown without hand-over");
	chk_bank_alternates: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
		sent |=> send_bank != $past(send_bank)) else $error("bank order broken");
	chk_idle_quiet: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
		state == upp_pkg::upp_tx_idle |-> !tx_valid) else $error("byte shown while idle");
	chk_token_answer: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
		start && scnt != '0 |=> tx_valid) else $error("token not answered");
	chk_data_stands: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
		tx_valid && !byte_taken |=> tx_valid && $stable(tx_data))
		else $error("byte changed before it was taken");
	chk_last_valid: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
		tx_last |-> tx_valid) else $error("last marker without a byte");
	chk_byte_count: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
		sent && scnt != '0 |-> n_taken + CW'(1) == scnt)
		else $error("bytes sent differ from bytes stored");
	chk_zlp_path: assert property (@(posedge core_clk) disable iff (!nrst) // RULE7
		start && scnt == '0 |=> (tx_zlp && !tx_valid) ##1 tx_done_flag)
		else $error("empty bank not sent as zero-length packet");

	// main scenarios
	cov_handover: cover property (@(posedge core_clk) handover);
	cov_two_ready: cover property (@(posedge core_clk) ready_q == 2'h3);
	cov_zlp: cover property (@(posedge core_clk) tx_zlp);
	cov_overflow: cover property (@(posedge core_clk) fifo_wr && cpu_bank && cnt1 == CW'(DEPTH));
	cov_slow_host: cover property (@(posedge core_clk) tx_valid && !byte_taken);
endmodule
`default_nettype wire

// *** rtl/upp_consts.svh ***
// constants for the ping-pong IN endpoint: widths, depths, reset values
// assumes inclusion by bare name from every design file that needs them
`ifndef UPP_CONSTS_SVH
`define UPP_CONSTS_SVH
`define UPP_DATA_W 8
`define UPP_BANK_DEPTH 64
`define UPP_CNT_W 7
`define UPP_FLAG_RST 1'b0
`endif

// *** rtl/upp_pkg.sv ***
// types for the ping-pong IN endpoint
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package upp_pkg;
	typedef enum logic [2:0] {
		upp_tx_idle = 3'b001,
		upp_tx_send = 3'b010,
		upp_tx_wait = 3'b100
	} upp_tx_state_e;
endpackage
`default_nettype wire

// *** rtl/upp_bank.sv ***
// one FIFO bank: byte store with a fill count, read by index
// assumes writes and reads of the same bank never overlap (ownership rule)
`include "upp_consts.svh"
`default_nettype none
module upp_bank #(
	parameter int DEPTH = `UPP_BANK_DEPTH,
	parameter int CW = `UPP_CNT_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// filling side
	input wire logic wr_en,
	input wire logic [`UPP_DATA_W-1:0] wr_data,
	input wire logic clr,
	// draining side
	input wire logic [CW-1:0] rd_idx,
	output logic [`UPP_DATA_W-1:0] rd_data,
	output logic [CW-1:0] count
);
	logic [`UPP_DATA_W-1:0] mem [DEPTH];
	wire full = (count == CW'(DEPTH));

	// storage has no reset; only the count matters for control
	always_ff @(posedge core_clk) begin
		if (wr_en && !full) begin
			mem[count[$clog2(DEPTH)-1:0]] <= wr_data;
		end
	end

	// count returns to zero when the bank is released
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
		end else if (clr) begin
			count <= '0;
		end else if (wr_en && !full) begin
			count <= count + CW'(1);
		end
	end

	assign rd_data = mem[rd_idx[$clog2(DEPTH)-1:0]];
endmodule
`default_nettype wire

// *** verification/upp_host_model.sv ***
// host-side model of the IN endpoint: sends tokens and takes bytes
// assumes the bench calls fetch and nothing else drives these pins
`default_nettype none
module upp_host_model (
	// clock
	input wire logic core_clk,
	// endpoint usb side
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_zlp,
	output logic in_token,
	output logic byte_taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	logic zlp;
	initial begin
		in_token = 1'b0;
		byte_taken = 1'b0;
	end
	// one IN transaction; stall spaces the byte strobes out like a slow host
	task automatic fetch(input int stall);
		int w;
		logic take;
		logic fin;
		got.delete();
		zlp = 1'b0;
		w = stall;
		fin = 1'b0;
		@(negedge core_clk) in_token = 1'b1;
		@(negedge core_clk);
		in_token = 1'b0;
		// bounded wait: a token with nothing ready simply runs out
		for (int i = 0; i < 200 && !fin; i++) begin
			take = tx_valid && w == 0;
			if (take) got.push_back(tx_data);
			if (tx_zlp || (take && tx_last)) fin = 1'b1;
			zlp |= tx_zlp;
			w = take ? stall : (w > 0 ? w - 1 : 0);
			byte_taken = take;
			@(negedge core_clk);
		end
		byte_taken = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the ping-pong IN endpoint
// assumes a bank depth of 4 so the overflow case stays short
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEPTH = 4;
	logic core_clk, nrst, fifo_wr, set_tx_packet_ready, clr_tx_done_flag;
	logic [7:0] fifo_wdata, tx_data;
	logic tx_packet_ready, tx_done_flag, ep_irq, cpu_bank, in_token, byte_taken;
	logic tx_valid, tx_last, tx_zlp;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	// the endpoint runs double-banked, as isochronous or full-rate bulk traffic needs
	upp_endpoint #(.DEPTH(DEPTH), .CW(3)) i_dut (
		.core_clk(core_clk), .nrst(nrst), .fifo_wr(fifo_wr), .fifo_wdata(fifo_wdata),
		.set_tx_packet_ready(set_tx_packet_ready), .clr_tx_done_flag(clr_tx_done_flag),
		.tx_packet_ready(tx_packet_ready), .tx_done_flag(tx_done_flag), .ep_irq(ep_irq),
		.cpu_bank(cpu_bank), .in_token(in_token), .byte_taken(byte_taken),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_zlp(tx_zlp));
	upp_host_model i_host (.core_clk(core_clk), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .tx_zlp(tx_zlp), .in_token(in_token), .byte_taken(byte_taken));
	// clock, and a ceiling well above the few hundred cycles the run needs
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic hand_over();
		@(negedge core_clk) set_tx_packet_ready = 1'b1;
		@(negedge core_clk) set_tx_packet_ready = 1'b0;
	endtask
	task automatic clear_done();
		@(negedge core_clk) clr_tx_done_flag = 1'b1;
		@(negedge core_clk) clr_tx_done_flag = 1'b0;
	endtask
	// n bytes counting up from base, one per cycle
	task automatic fill(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk);
			fifo_wr = 1'b1;
			fifo_wdata = base + 8'(i);
		end
		@(negedge core_clk) fifo_wr = 1'b0;
	endtask
	task automatic expect_bytes(input int n, input logic [7:0] base);
		check("count", 8'(i_host.got.size()), 8'(n));
		foreach (i_host.got[i]) check("byte", i_host.got[i], base + 8'(i));
	endtask
	task automatic t_reset();
		check("idle", {3'b000, cpu_bank, tx_packet_ready, tx_done_flag, ep_irq, tx_valid},
			8'h00);
	endtask
	task automatic t_pingpong();
		fill(3, 8'h10);
		hand_over();
		check("ready bank", {6'h00, tx_packet_ready, cpu_bank}, 8'h03);
		fill(2, 8'h20);
		i_host.fetch(0);
		expect_bytes(3, 8'h10);
		check("done irq rdy", {5'h00, tx_done_flag, ep_irq, tx_packet_ready}, 8'h06);
		i_host.fetch(0);
		expect_bytes(0, 8'h00);
		check("irq held", 8'(ep_irq), 8'h01);
		clear_done();
		check("irq clr", {6'h00, tx_done_flag, ep_irq}, 8'h00);
		hand_over();
		check("bank back", 8'(cpu_bank), 8'h00);
		i_host.fetch(2);
		expect_bytes(2, 8'h20);
		clear_done();
	endtask
	// empty bank goes out as a zero-length packet
	task automatic t_zero_len();
		hand_over();
		i_host.fetch(0);
		@(negedge core_clk);
		check("zlp done", {6'h00, i_host.zlp, tx_done_flag}, 8'h03);
		clear_done();
	endtask
	task automatic t_overflow();
		fill(DEPTH + 1, 8'h30);
		hand_over();
		i_host.fetch(1);
		expect_bytes(DEPTH, 8'h30);
		clear_done();
	endtask
	// reset after a hand-over drops both banks and every flag, then a packet still goes out
	task automatic t_mid_reset();
		fill(2, 8'h40);
		hand_over();
		@(negedge core_clk) nrst = 1'b0;
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		@(negedge core_clk);
		check("reset idle", {3'b000, cpu_bank, tx_packet_ready, tx_done_flag, ep_irq, tx_valid},
			8'h00);
		fill(1, 8'h50);
		hand_over();
		i_host.fetch(0);
		expect_bytes(1, 8'h50);
		check("done after reset", 8'(tx_done_flag), 8'h01);
		clear_done();
	endtask
	initial begin
		nrst = 1'b0;
		fifo_wr = 1'b0;
		fifo_wdata = 8'h00;
		set_tx_packet_ready = 1'b0;
		clr_tx_done_flag = 1'b0;
		repeat (20) @(negedge core_clk);
		nrst = 1'b1;
		@(negedge core_clk);
		t_reset();
		t_pingpong();
		t_zero_len();
		t_overflow();
		t_mid_reset();
		complete_run();
	end
endmodule
`default_nettype wire
